/* hw/pcm_pkg.sv */
// Shared constants and types of the preset counter block
package pcm_pkg;
  localparam int unsigned CNT_W      = 20;
  localparam int unsigned TIME_W     = 14;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_PRE1   = 8'h04;
  localparam logic [7:0]  OFF_PRE2   = 8'h08;
  localparam logic [7:0]  OFF_TIME1  = 8'h0C;
  localparam logic [7:0]  OFF_TIME2  = 8'h10;
  localparam logic [7:0]  OFF_COUNT  = 8'h14;
  localparam logic [7:0]  OFF_STAT   = 8'h18;
  localparam logic [7:0]  OFF_CMD    = 8'h1C;
  // Field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_DUAL_BIT = 4;
  localparam int unsigned CTRL_PNL_BIT  = 5;
  localparam int unsigned CMD_RST_BIT   = 0;
  // Reset values
  localparam logic [3:0]        RST_MODE  = 4'h0;
  localparam logic              RST_DUAL  = 1'b1;
  localparam logic              RST_PNL   = 1'b1;
  localparam logic [CNT_W-1:0]  RST_PRE1  = 20'h001F4;
  localparam logic [CNT_W-1:0]  RST_PRE2  = 20'h003E8;
  localparam logic [TIME_W-1:0] RST_TIME  = 14'h000A;
  // On-time limits in hundredths of a second
  localparam logic [TIME_W-1:0] TIME_MIN  = 14'h0001;
  localparam logic [TIME_W-1:0] TIME_MAX  = 14'h270F;
  // Timer tick
  localparam int unsigned TICK_MS     = 10;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;

  typedef enum logic [2:0] {
    ST_INIT = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } pcm_state_t;
endpackage

/* hw/pcm_sync.sv */
// Two-flop synchroniser with rising edge detect
`timescale 1ns/100ps
module pcm_sync (
  input  wire logic sys_clk, // System clock
  input  wire logic reset,   // Synchronous reset
  input  wire logic din,     // Asynchronous pin
  output logic      level,   // Synchronised level
  output logic      rise     // One-cycle rising edge
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } pcm_sync_t;

  pcm_sync_t s_q;
  pcm_sync_t s_d;

  always_comb
  begin
    s_d    = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign level = s_q.s2;
  assign rise  = s_q.s2 & ~s_q.s3;
endmodule

/* hw/pcm_timer.sv */
// On-time timer for one output, counting 10 ms ticks
`timescale 1ns/100ps
module pcm_timer (
  input  wire logic                      sys_clk,  // System clock
  input  wire logic                      reset,    // Synchronous reset
  input  wire logic                      tick,     // 10 ms tick
  input  wire logic                      start,    // Start or restart
  input  wire logic                      clear,    // Abort
  input  wire logic [pcm_pkg::TIME_W-1:0] time_val, // On-time in hundredths
  output logic                           active,   // Timer running
  output logic                           done      // End pulse
);
  typedef struct packed {
    logic                      act;
    logic                      fin;
    logic [pcm_pkg::TIME_W-1:0] left;
  } pcm_tmr_t;

  pcm_tmr_t s_q;
  pcm_tmr_t s_d;

  always_comb
  begin
    s_d     = s_q;
    s_d.fin = 1'b0;
    if (clear)
    begin
      s_d.act  = 1'b0;
      s_d.left = '0;
    end
    else if (start)
    begin
      s_d.act = 1'b1;
      // Out-of-range settings are clamped into the legal span
      if (time_val < pcm_pkg::TIME_MIN)
        s_d.left = pcm_pkg::TIME_MIN;
      else if (time_val > pcm_pkg::TIME_MAX)
        s_d.left = pcm_pkg::TIME_MAX;
      else
        s_d.left = time_val;
    end
    else if (s_q.act && tick)
    begin
      if (s_q.left == pcm_pkg::TIME_MIN)
      begin
        s_d.act = 1'b0;
        s_d.fin = 1'b1;
      end
      else
        s_d.left = s_q.left - pcm_pkg::TIME_MIN;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign active = s_q.act;
  assign done   = s_q.fin;

  property p_start_act;
    @(posedge sys_clk) disable iff (reset) start && !clear |=> s_q.act && s_q.left != '0;
  endproperty
  a_start_act: assert property (p_start_act) else $error("timer not running after start");

  property p_done_idle;
    @(posedge sys_clk) disable iff (reset) s_q.fin |-> !s_q.act && $past(s_q.act);
  endproperty
  a_done_idle: assert property (p_done_idle) else $error("timer end without prior run");
endmodule

/* hw/pcm_preset_counter.sv */
// Mode-controlled preset counter with APB registers
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
module pcm_preset_counter #(
  parameter int unsigned TICK_CYCLES = pcm_pkg::TICK_CYCLES // Cycles per 10 ms tick
) (
  input  wire logic        sys_clk,               // 100 MHz clock
  input  wire logic        reset,                 // Synchronous reset
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB direction
  input  wire logic [7:0]  paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic      [31:0] prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error
  input  wire logic        count_pulse_in,        // Count pulses, rising edge
  input  wire logic        count_direction_input, // High up, low down
  input  wire logic        remote_reset_n,        // Remote reset, low active
  output logic             out1,                  // Output 1
  output logic             out2                   // Output 2
);
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);

  typedef struct packed {
    pcm_pkg::pcm_state_t             st;
    logic [3:0]                      mode;
    logic                            dual;
    logic                            pnl_en;
    logic [pcm_pkg::CNT_W-1:0]       p1;
    logic [pcm_pkg::CNT_W-1:0]       p2;
    logic [pcm_pkg::TIME_W-1:0]      t1;
    logic [pcm_pkg::TIME_W-1:0]      t2;
    logic [pcm_pkg::CNT_W-1:0]       cnt;
    logic                            lat1;
    logic                            lat2;
    logic                            o1;
    logic                            o2;
    logic [19:0]                     tick_cnt;
    logic                            tick;
    logic                            rdy;
    logic                            err;
    logic [31:0]                     rdat;
  } pcm_regs_t;

  pcm_regs_t                 s_q;
  pcm_regs_t                 s_d;
  logic [2:0]                pin_lvl;
  logic [2:0]                pin_rise;
  logic [1:0]                t_act;
  logic [1:0]                t_done;
  logic [1:0]                t_start;
  logic                      t_clr;
  logic [1:0][pcm_pkg::TIME_W-1:0] t_val;
  logic                      pulse;
  logic                      up;
  logic                      mrst;
  logic                      cmd_rst;
  logic                      wr_en;
  logic                      mode_ok;
  logic                      rtp;
  logic                      tm1;
  logic                      tm2;
  logic                      off1;
  logic                      at_tgt;
  logic                      aft;
  logic                      h1;
  logic                      h2;
  logic                      h_auto;
  logic                      h_done;
  logic                      running;
  logic [pcm_pkg::CNT_W-1:0] start_v;
  logic [pcm_pkg::CNT_W-1:0] step_v;
  logic [pcm_pkg::CNT_W-1:0] nxt;
  logic [pcm_pkg::CNT_W-1:0] tgt1;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin
      pcm_sync u_sync (
        .sys_clk (sys_clk),
        .reset   (reset),
        .din     (gi == 0 ? count_pulse_in : (gi == 1 ? count_direction_input : remote_reset_n)),
        .level   (pin_lvl[gi]),
        .rise    (pin_rise[gi])
      );
    end
    for (gi = 0; gi < 2; gi++)
    begin : g_tmr
      pcm_timer u_tmr (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .tick     (s_q.tick),
        .start    (t_start[gi]),
        .clear    (t_clr),
        .time_val (t_val[gi]),
        .active   (t_act[gi]),
        .done     (t_done[gi])
      );
    end
  endgenerate

  assign t_val = {s_q.t2, s_q.t1};
  assign pulse = pin_rise[0];
  assign up    = pin_lvl[1];
  assign wr_en = psel & penable & s_q.rdy & pwrite;
  assign cmd_rst = wr_en && paddr == pcm_pkg::OFF_CMD && pwdata[pcm_pkg::CMD_RST_BIT] && s_q.pnl_en;
  assign mrst  = ~pin_lvl[2] | cmd_rst;
  assign running = s_q.st != pcm_pkg::ST_INIT;

  // Mode decode; dual codes 8..15 are not built and act as invalid
  always_comb
  begin
    rtp    = 1'b0;
    tm1    = 1'b0;
    tm2    = 1'b0;
    off1   = 1'b0;
    at_tgt = 1'b0;
    aft    = 1'b0;
    if (s_q.dual)
    begin
      mode_ok = ~s_q.mode[3];
      case (s_q.mode[2:0])
        3'h0: ;
        3'h1: begin tm1 = 1'b1; tm2 = 1'b1; end
        3'h2: off1 = 1'b1;
        3'h3: begin off1 = 1'b1; tm2 = 1'b1; end
        3'h4: begin off1 = 1'b1; tm2 = 1'b1; at_tgt = 1'b1; end
        3'h5: begin tm1 = 1'b1; tm2 = 1'b1; at_tgt = 1'b1; end
        3'h6: begin off1 = 1'b1; tm2 = 1'b1; aft = 1'b1; end
        3'h7: begin tm1 = 1'b1; tm2 = 1'b1; aft = 1'b1; end
        default: ;
      endcase
    end
    else
    begin
      mode_ok = s_q.mode[2] ? ~s_q.mode[0] : ~s_q.mode[1];
      rtp     = s_q.mode[3];
      tm1     = s_q.mode[0] | s_q.mode[2];
      at_tgt  = s_q.mode[2] & ~s_q.mode[1];
      aft     = s_q.mode[2] & s_q.mode[1];
    end
  end

  // Hits are judged on the value just counted, so a count moving either way still triggers
  always_comb
  begin
    start_v = rtp ? s_q.p1 : '0;
    tgt1    = (rtp && !s_q.dual) ? '0 : s_q.p1;
    nxt     = up ? s_q.cnt + 20'h00001 : s_q.cnt - 20'h00001;
    step_v  = pulse ? (up ? start_v + 20'h00001 : start_v - 20'h00001) : start_v;
    h1      = pulse && nxt == tgt1;
    h2      = s_q.dual && pulse && nxt == s_q.p2;
    h_auto  = at_tgt && (s_q.dual ? h2 : h1);
    h_done  = s_q.st == pcm_pkg::ST_HOLD && (s_q.dual ? t_done[1] : t_done[0]);
  end

  always_comb
  begin
    s_d      = s_q;
    t_start  = 2'b00;
    t_clr    = 1'b0;
    // Free-running tick keeps timers independent of count activity
    s_d.tick = s_q.tick_cnt == TICK_LAST;
    s_d.tick_cnt = s_d.tick ? 20'h00000 : s_q.tick_cnt + 20'h00001;
    case (s_q.st)
      pcm_pkg::ST_INIT:
      begin
        s_d.cnt  = start_v;
        s_d.lat1 = 1'b0;
        s_d.lat2 = 1'b0;
        s_d.st   = pcm_pkg::ST_RUN;
      end
      pcm_pkg::ST_RUN, pcm_pkg::ST_HOLD:
      begin
        if (mrst)
        begin
          // A pulse in the same cycle is dropped on purpose: reset wins
          s_d.cnt  = start_v;
          s_d.lat1 = 1'b0;
          s_d.lat2 = 1'b0;
          t_clr    = 1'b1;
          s_d.st   = pcm_pkg::ST_RUN;
        end
        else if (!mode_ok)
        begin
          if (pulse)
            s_d.cnt = nxt;
          s_d.lat1 = 1'b0;
          s_d.lat2 = 1'b0;
          t_clr    = 1'b1;
          s_d.st   = pcm_pkg::ST_RUN;
        end
        else
        begin
          if (pulse)
            s_d.cnt = nxt;
          if (h1)
          begin
            if (tm1)
              t_start[0] = 1'b1;
            else
              s_d.lat1 = 1'b1;
          end
          if (h2)
          begin
            if (off1)
              s_d.lat1 = 1'b0;
            if (tm2)
              t_start[1] = 1'b1;
            else
              s_d.lat2 = 1'b1;
          end
          if (h_auto)
            s_d.cnt = start_v;
          if (aft && (s_q.dual ? h2 : h1))
            s_d.st = pcm_pkg::ST_HOLD;
          if (h_done)
          begin
            // The pulse of this cycle lands on top of the reload
            s_d.cnt = step_v;
            s_d.st  = pcm_pkg::ST_RUN;
          end
        end
      end
      default: s_d.st = pcm_pkg::ST_INIT;
    endcase
    s_d.o1 = s_d.lat1 | t_act[0];
    s_d.o2 = s_d.lat2 | t_act[1];

    // APB: decode in setup, answer in the first access cycle
    s_d.rdy  = psel & ~penable;
    s_d.err  = 1'b0;
    s_d.rdat = '0;
    if (psel && !penable)
    begin
      case (paddr)
        pcm_pkg::OFF_CTRL:  s_d.rdat = {26'h0, s_q.pnl_en, s_q.dual, s_q.mode};
        pcm_pkg::OFF_PRE1:  s_d.rdat = {12'h000, s_q.p1};
        pcm_pkg::OFF_PRE2:  s_d.rdat = {12'h000, s_q.p2};
        pcm_pkg::OFF_TIME1: s_d.rdat = {18'h0, s_q.t1};
        pcm_pkg::OFF_TIME2: s_d.rdat = {18'h0, s_q.t2};
        pcm_pkg::OFF_COUNT: s_d.rdat = {12'h000, s_q.cnt};
        pcm_pkg::OFF_STAT:  s_d.rdat = {26'h0, s_q.st == pcm_pkg::ST_HOLD, up, t_act, s_q.o2, s_q.o1};
        pcm_pkg::OFF_CMD:   s_d.rdat = '0;
        default:            s_d.err  = 1'b1;
      endcase
    end
    if (wr_en)
    begin
      case (paddr)
        pcm_pkg::OFF_CTRL:
        begin
          s_d.mode   = pwdata[pcm_pkg::CTRL_MODE_LSB +: 4];
          s_d.dual   = pwdata[pcm_pkg::CTRL_DUAL_BIT];
          s_d.pnl_en = pwdata[pcm_pkg::CTRL_PNL_BIT];
        end
        pcm_pkg::OFF_PRE1:  s_d.p1 = pwdata[pcm_pkg::CNT_W-1:0];
        pcm_pkg::OFF_PRE2:  s_d.p2 = pwdata[pcm_pkg::CNT_W-1:0];
        pcm_pkg::OFF_TIME1: s_d.t1 = pwdata[pcm_pkg::TIME_W-1:0];
        pcm_pkg::OFF_TIME2: s_d.t2 = pwdata[pcm_pkg::TIME_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_q        <= '0;
      s_q.st     <= pcm_pkg::ST_INIT;
      s_q.mode   <= pcm_pkg::RST_MODE;
      s_q.dual   <= pcm_pkg::RST_DUAL;
      s_q.pnl_en <= pcm_pkg::RST_PNL;
      s_q.p1     <= pcm_pkg::RST_PRE1;
      s_q.p2     <= pcm_pkg::RST_PRE2;
      s_q.t1     <= pcm_pkg::RST_TIME;
      s_q.t2     <= pcm_pkg::RST_TIME;
    end
    else
      s_q <= s_d;
  end

  assign prdata  = s_q.rdat;
  assign pready  = s_q.rdy;
  assign pslverr = s_q.err;
  assign out1    = s_q.o1;
  assign out2    = s_q.o2;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_mrst_start;
    running && mrst |=> s_q.cnt == $past(start_v) && !s_q.lat1 && !s_q.lat2;
  endproperty
  a_mrst_start: assert property (p_mrst_start) else $error("manual reset did not restart");

  property p_count_up;
    running && !mrst && pulse && up && !h_auto && !h_done |=> s_q.cnt == $past(s_q.cnt) + 20'h00001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("up count missed");

  property p_count_dn;
    running && !mrst && pulse && !up && !h_auto && !h_done |=> s_q.cnt == $past(s_q.cnt) - 20'h00001;
  endproperty
  a_count_dn: assert property (p_count_dn) else $error("down count missed");

  property p_auto_now;
    running && !mrst && mode_ok && h_auto |=> s_q.cnt == $past(start_v);
  endproperty
  a_auto_now: assert property (p_auto_now) else $error("automatic reset at target missed");

  property p_auto_after;
    !mrst && mode_ok && h_done |=> s_q.cnt == $past(step_v) && s_q.st == pcm_pkg::ST_RUN;
  endproperty
  a_auto_after: assert property (p_auto_after) else $error("reload after timer lost a count");

  property p_latch_on;
    running && !mrst && mode_ok && h1 && !tm1 |=> s_q.o1 ##1 s_q.o1 || mrst;
  endproperty
  a_latch_on: assert property (p_latch_on) else $error("latched output not on");

  property p_timed_on;
    t_start[0] && !mrst |=> ##1 s_q.o1;
  endproperty
  a_timed_on: assert property (p_timed_on) else $error("timed output not on");

  property p_invalid_off;
    !mode_ok ##1 !mode_ok |=> !s_q.o1 && !s_q.o2;
  endproperty
  a_invalid_off: assert property (p_invalid_off) else $error("output active in unbuilt mode");

  property p_off_at_p2;
    running && !mrst && mode_ok && s_q.dual && off1 && h2 |=> !s_q.lat1 && s_q.o2 == !$past(tm2);
  endproperty
  a_off_at_p2: assert property (p_off_at_p2) else $error("output 1 not off at preset 2");

  property p_tick_gap;
    s_q.tick |=> !s_q.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick longer than one cycle");
endmodule

/* verification/pcm_pulse_src.sv */
// Count pulse source standing in for the field sensor
`timescale 1ns/100ps
module pcm_pulse_src (
  input  wire logic       sys_clk, // Clock
  input  wire logic       reset,   // Sync reset
  input  wire logic       go,      // Start a burst
  input  wire logic [7:0] n,       // Pulses per burst
  output logic            busy,    // Burst running
  output logic            pulse    // Count pin
);
  // Three cycles high and low clears the two-clock minimum with margin
  logic [10:0] left_q;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      left_q <= 11'h000;
    else if (go && !busy)
      left_q <= 11'(n) * 11'h006;
    else if (busy)
      left_q <= left_q - 11'h001;
  end
  assign busy  = left_q != 11'h000;
  assign pulse = busy && ((left_q % 11'h006) >= 11'h003);
endmodule

/* verification/tb_pcm_preset_counter.sv */
// Self-checking bench for the preset counter block
`timescale 1ns/100ps
module tb_pcm_preset_counter;
  logic        sys_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pulse;
  logic        dir;
  logic        rrst_n;
  logic        out1;
  logic        out2;
  logic        go;
  logic [7:0]  n;
  logic        busy;
  logic [31:0] rv;
  logic        ev;
  int          bad_count;
  int          n_checks;
  int          cyc;

  pcm_preset_counter #(.TICK_CYCLES(10)) pcm_preset_counter_inst (
    .sys_clk              (sys_clk),
    .reset                (reset),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .count_pulse_in       (pulse),
    .count_direction_input(dir),
    .remote_reset_n       (rrst_n),
    .out1                 (out1),
    .out2                 (out2)
  );

  pcm_pulse_src pcm_pulse_src_inst (
    .sys_clk(sys_clk),
    .reset  (reset),
    .go     (go),
    .n      (n),
    .busy   (busy),
    .pulse  (pulse)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Runs are well under 10000 cycles; reaching 20000 cycles is taken as a hang
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      bad_count++;
    end
  endtask

  // Entered just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rv, e);
  endtask

  task automatic cnt(input logic [31:0] e);
    rd(pcm_pkg::OFF_COUNT, e);
  endtask

  task automatic outs(input logic [1:0] e);
    chk({30'h0, out2, out1}, {30'h0, e});
  endtask

  task automatic mode(input logic d, input logic [3:0] m);
    wr(pcm_pkg::OFF_CTRL, {26'h0, 1'b1, d, m});
  endtask

  task automatic mrst();
    wr(pcm_pkg::OFF_CMD, 32'h00000001);
  endtask

  task automatic burst(input logic [7:0] k);
    go <= 1'b1;
    n  <= k;
    @(posedge sys_clk);
    go <= 1'b0;
    @(posedge sys_clk);
    while (busy === 1'b1) @(posedge sys_clk);
    // Sync, edge detect and count update take three cycles
    repeat (8) @(posedge sys_clk);
  endtask

  initial
  begin
    reset   = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    dir     = 1'b1;
    rrst_n  = 1'b1;
    go      = 1'b0;
    n       = 8'h00;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(pcm_pkg::OFF_CTRL, 32'h00000030);
    rd(pcm_pkg::OFF_PRE1, 32'h000001F4);
    rd(pcm_pkg::OFF_PRE2, 32'h000003E8);
    rd(pcm_pkg::OFF_TIME2, 32'h0000000A);
    cnt(32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000);
    chk({31'h0, ev}, 32'h00000001);
    mode(1'b0, 4'h0);
    wr(pcm_pkg::OFF_PRE1, 32'h00000003);
    mrst();
    burst(8'h02);
    cnt(32'h00000002);
    outs(2'h0);
    burst(8'h01);
    outs(2'h1);
    burst(8'h01);
    cnt(32'h00000004);
    mrst();
    cnt(32'h00000000);
    outs(2'h0);
    burst(8'h03);
    rrst_n <= 1'b0;
    burst(8'h02);
    cnt(32'h00000000);
    outs(2'h0);
    rrst_n <= 1'b1;
    wr(pcm_pkg::OFF_PRE1, 32'h000FFFFE);
    dir <= 1'b0;
    burst(8'h02);
    cnt(32'h000FFFFE);
    outs(2'h1);
    mrst();
    dir <= 1'b1;
    wr(pcm_pkg::OFF_PRE1, 32'h00000003);
    wr(pcm_pkg::OFF_TIME1, 32'h00000003);
    mode(1'b0, 4'h4);
    mrst();
    burst(8'h03);
    outs(2'h1);
    cnt(32'h00000000);
    repeat (40) @(posedge sys_clk);
    outs(2'h0);
    burst(8'h04);
    cnt(32'h00000001);
    mode(1'b0, 4'h6);
    mrst();
    burst(8'h03);
    cnt(32'h00000003);
    repeat (40) @(posedge sys_clk);
    cnt(32'h00000000);
    for (int i = 0; i < 2; i++)
    begin
      dir <= (i == 0);
      mode(1'b0, (i == 0) ? 4'h1 : 4'h9);
      mrst();
      burst(8'h03);
      outs(2'h1);
      cnt((i == 0) ? 32'h00000003 : 32'h00000000);
      repeat (40) @(posedge sys_clk);
      outs(2'h0);
    end
    mode(1'b0, 4'h8);
    mrst();
    cnt(32'h00000003);
    burst(8'h03);
    outs(2'h1);
    burst(8'h01);
    cnt(32'h000FFFFF);
    mrst();
    cnt(32'h00000003);
    outs(2'h0);
    mode(1'b0, 4'hC);
    mrst();
    burst(8'h03);
    outs(2'h1);
    cnt(32'h00000003);
    repeat (40) @(posedge sys_clk);
    mode(1'b0, 4'hE);
    mrst();
    burst(8'h03);
    cnt(32'h00000000);
    // Waiting for timer end, counting down, timer 1 running, output 1 on
    rd(pcm_pkg::OFF_STAT, 32'h00000025);
    repeat (40) @(posedge sys_clk);
    cnt(32'h00000003);
    dir <= 1'b1;
    mode(1'b0, 4'h2);
    mrst();
    burst(8'h03);
    cnt(32'h00000003);
    outs(2'h0);
    mode(1'b1, 4'h2);
    wr(pcm_pkg::OFF_PRE2, 32'h00000005);
    mrst();
    burst(8'h03);
    outs(2'h1);
    burst(8'h02);
    outs(2'h2);
    mrst();
    outs(2'h0);
    wr(pcm_pkg::OFF_TIME1, 32'h0000000A);
    wr(pcm_pkg::OFF_PRE1, 32'h00000001);
    wr(pcm_pkg::OFF_PRE2, 32'h00000002);
    mode(1'b1, 4'h5);
    mrst();
    burst(8'h02);
    outs(2'h3);
    cnt(32'h00000000);
    // A zero on-time must clamp to one tick, not wrap into a very long pulse
    wr(pcm_pkg::OFF_TIME1, 32'h00000000);
    mode(1'b1, 4'h0);
    mrst();
    burst(8'h02);
    outs(2'h3);
    mrst();
    cnt(32'h00000000);
    outs(2'h0);
    mode(1'b1, 4'h1);
    mrst();
    burst(8'h02);
    outs(2'h2);
    cnt(32'h00000002);
    repeat (100) @(posedge sys_clk);
    outs(2'h0);
    // Output 1 is gone by preset 2 in all four modes: switched off or one tick long
    for (int j = 3; j < 8; j++)
    begin
      if (j != 5)
      begin
        mode(1'b1, 4'(j));
        mrst();
        burst(8'h02);
        outs(2'h2);
        cnt((j == 4) ? 32'h00000000 : 32'h00000002);
        repeat (100) @(posedge sys_clk);
        cnt((j == 3) ? 32'h00000002 : 32'h00000000);
        outs(2'h0);
      end
    end
    mode(1'b1, 4'hA);
    mrst();
    burst(8'h02);
    cnt(32'h00000002);
    outs(2'h0);
    final_report();
  end
endmodule
